// ==== timer_compare_match_unit.sv ====
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
// Compare unit: Wishbone registers, match actions and pin routing
module timer_compare_match_unit
  import compare_pkg::*;
#(
  parameter bit SECOND_UNIT = 1'b0  // Set for the second compare unit
)
(
  input  wire logic        clk_i,                 // System clock
  input  wire logic        rst_i,                 // Synchronous reset
  // Wishbone slave
  input  wire logic        cyc_i,                 // Bus cycle
  input  wire logic        stb_i,                 // Strobe
  input  wire logic        we_i,                  // Write enable
  input  wire logic [7:0]  adr_i,                 // Byte address
  input  wire logic [3:0]  sel_i,                 // Byte lanes
  input  wire logic [31:0] dat_i,                 // Write data
  output logic [31:0]      dat_o,                 // Read data
  output logic             ack_o,                 // Acknowledge
  // Timer side
  input  wire logic [15:0] timer_one_count_i,     // Timer count pair
  input  wire logic        timer_tick_i,          // Timer clock edge
  output logic             timer_clear_o,         // Clear timer pair
  // Event outputs
  output logic             trigger_o,             // Special event
  output logic             adc_go_o,              // Start conversion
  output logic             compare_match_flag_o,  // Match flag
  // Pins
  output logic             port_c_pin_one_o,      // Pin level
  output logic             port_c_pin_one_oe_n_o, // Drive, low active
  output logic             port_b_pin_three_o,    // Pin level
  output logic             port_b_pin_three_oe_n_o // Drive, low active
);

  typedef struct packed {
    logic        ack;      // Bus answer
    logic [31:0] rdata;    // Bus read data
    logic [3:0]  mode;     // Compare mode select
    logic        pin_sel;  // Alternate pin for second unit
    logic [15:0] value;    // Compare value pair
    logic        flag;     // Compare match flag
    logic        trig;     // Special event pulse
    logic        pending;  // Timer reset awaiting timer edge
    logic        tclr;     // Timer clear pulse
    logic        adc_go;   // Conversion start pulse
    logic        pin_c;    // Level on first pin
    logic        pin_c_n;  // First pin drive, low active
    logic        pin_b;    // Level on alternate pin
    logic        pin_b_n;  // Alternate pin drive, low active
  } unit_state_type;

  unit_state_type state_reg;
  unit_state_type state_next;

  logic        cmp_en;     // Compare mode selected
  logic        equal;      // Live equality
  logic        rise;       // Entry into equality
  logic        level;      // Output latch level
  logic        drive;      // Mode owns the pin
  logic        bus_req;    // Request present
  logic        wr_take;    // Write takes effect this edge
  logic        wr_ctrl;    // Control write
  logic        force_low;  // Zero written to control
  logic        special;    // Trigger mode selected

  // Compare is active only in the compare mode codes
  assign cmp_en = (state_reg.mode == MODE_TOGGLE) ||
                  (state_reg.mode == MODE_SET) ||
                  (state_reg.mode == MODE_CLEAR) ||
                  (state_reg.mode == MODE_SWINT) ||
                  (state_reg.mode == MODE_SPECIAL); // see [RULE1]
  assign special = state_reg.mode == MODE_SPECIAL;  // see [RULE11]

  // Bus decode; writes land on the acknowledging edge
  assign bus_req   = cyc_i && stb_i;
  assign wr_take   = bus_req && we_i && state_reg.ack;
  assign wr_ctrl   = wr_take && sel_i[0] && (adr_i == CTRL_OFFSET);
  assign force_low = wr_ctrl && (dat_i[CTRL_W-1:0] == '0); // see [RULE7]

  // Equality and entry edge
  compare_match_detect u_detect (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .enable_i (cmp_en),
    .value_i  (state_reg.value),
    .count_i  (timer_one_count_i),
    .equal_o  (equal),
    .rise_o   (rise)
  );

  // Output latch
  compare_out_latch u_latch (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .match_i     (rise),
    .mode_i      (state_reg.mode),
    .force_low_i (force_low),
    .level_o     (level),
    .drive_o     (drive)
  );

  // Next state of bus, registers, events and pins
  always_comb begin
    state_next        = state_reg;
    // Ack for one cycle, then drop
    state_next.ack    = bus_req && !state_reg.ack;
    state_next.rdata  = '0;
    if (bus_req && !state_reg.ack && !we_i) begin
      case (adr_i)
        CTRL_OFFSET: begin
          state_next.rdata[MODE_LSB +: MODE_W] = state_reg.mode;
          state_next.rdata[PIN_SEL_BIT]        = state_reg.pin_sel;
        end
        VALUE_OFFSET: begin
          state_next.rdata[15:0] = state_reg.value;
        end
        FLAG_OFFSET: begin
          state_next.rdata[FLAG_BIT] = state_reg.flag;
        end
        STATUS_OFFSET: begin
          state_next.rdata[ST_EQUAL_BIT] = equal;
          state_next.rdata[ST_LEVEL_BIT] = level;
          state_next.rdata[ST_PEND_BIT]  = state_reg.pending;
        end
        default: begin
          // Unmapped reads answer zero
          state_next.rdata = '0;
        end
      endcase
    end
    // Register writes
    if (wr_ctrl) begin
      state_next.mode    = dat_i[MODE_LSB +: MODE_W];
      state_next.pin_sel = dat_i[PIN_SEL_BIT];
    end
    if (wr_take && adr_i == VALUE_OFFSET) begin
      if (sel_i[0]) begin
        state_next.value[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
        state_next.value[15:8] = dat_i[15:8];
      end
    end
    // Flag: write one clears, a match in the same cycle wins
    state_next.flag = state_reg.flag;
    if (wr_take && sel_i[0] && adr_i == FLAG_OFFSET && dat_i[FLAG_BIT]) begin
      state_next.flag = 1'b0;
    end
    if (rise) begin
      state_next.flag = 1'b1; // see [RULE3] [RULE10]
    end
    // Trigger fires on the match itself
    state_next.trig   = rise && special;                // see [RULE2] [RULE12]
    state_next.adc_go = rise && special && SECOND_UNIT; // see [RULE6]
    // Timer reset waits for the timer edge while the match holds
    state_next.tclr = 1'b0;
    if (rise && special) begin
      state_next.pending = 1'b1; // see [RULE12]
    end else if (state_reg.pending && !equal) begin
      state_next.pending = 1'b0; // see [RULE13]
    end else if (state_reg.pending && timer_tick_i) begin
      // Clears both bytes; the overflow flag path is untouched
      state_next.pending = 1'b0;
      state_next.tclr    = 1'b1; // see [RULE4] [RULE5] [RULE12]
    end
    // Pin routing; second unit picks one of two pins
    state_next.pin_c   = level;
    state_next.pin_b   = level;
    state_next.pin_c_n = !(drive && !(SECOND_UNIT && state_reg.pin_sel));
    state_next.pin_b_n = !(drive && SECOND_UNIT && state_reg.pin_sel); // see [RULE8]
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg         <= '0;
      state_reg.mode    <= MODE_RST;
      state_reg.value   <= VALUE_RST;
      state_reg.pin_c_n <= 1'b1;
      state_reg.pin_b_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign dat_o                   = state_reg.rdata;
  assign ack_o                   = state_reg.ack;
  assign timer_clear_o           = state_reg.tclr;
  assign trigger_o               = state_reg.trig;
  assign adc_go_o                = state_reg.adc_go;
  assign compare_match_flag_o    = state_reg.flag;
  assign port_c_pin_one_o        = state_reg.pin_c;
  assign port_c_pin_one_oe_n_o   = state_reg.pin_c_n;
  assign port_b_pin_three_o      = state_reg.pin_b;
  assign port_b_pin_three_oe_n_o = state_reg.pin_b_n;

  // Match in trigger mode
  sequence special_match_s;
    rise && special;
  endsequence

  // Pending reset meeting the timer edge with match kept
  sequence reset_due_s;
    state_reg.pending && timer_tick_i && equal && !rise;
  endsequence

  // Ack lasts one cycle
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held more than one cycle");

  // Any compare match raises the flag
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise |=> compare_match_flag_o) // see [RULE3]
    else $error("match did not set flag");

  // Trigger follows a trigger-mode match at once
  trig_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
    special_match_s |=> trigger_o && !timer_clear_o) // see [RULE12]
    else $error("trigger late or timer cleared early");

  // Other modes never trigger
  trig_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && !special |=> !trigger_o && !adc_go_o) // see [RULE2]
    else $error("trigger outside trigger mode");

  // Timer edge with match held clears the timer
  timer_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reset_due_s |=> timer_clear_o) // see [RULE4] [RULE12]
    else $error("timer not cleared on timer edge");

  // Lost match cancels the reset
  reset_cancel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg.pending && !equal && !rise |=> !state_reg.pending
    ##1 !timer_clear_o) // see [RULE13]
    else $error("timer reset after match vanished");

  // Conversion start only on the second unit
  adc_unit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    special_match_s |=> adc_go_o == SECOND_UNIT) // see [RULE6]
    else $error("conversion start on wrong unit");

  // Alternate pin only on second unit with select set
  pin_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_b_pin_three_oe_n_o |-> SECOND_UNIT && port_c_pin_one_oe_n_o)
    // see [RULE8]
    else $error("alternate pin misrouted");

  // Flag-only and trigger modes leave the pins alone
  pin_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg.mode == MODE_SWINT || special) [*2]
    |-> port_c_pin_one_oe_n_o && port_b_pin_three_oe_n_o) // see [RULE10]
    else $error("pin driven in flag-only mode");

endmodule

// ==== compare_pkg.sv ====
// Operation
// [RULE1] Compare value continuously checked against timer count
// [RULE2] Match performs one action chosen by mode
// [RULE3] Every compare mode sets the match flag
// [RULE4] Trigger clears timer high and low bytes
// [RULE5] Trigger clear never sets timer overflow flag
// [RULE6] Second unit trigger also starts conversion
// [RULE7] Zero control write forces output latch low
// [RULE8] Second unit output routes to selectable pin
// [RULE9] Software clears pin direction bit first
// [RULE10] Mode 1010 flags only, pin uncontrolled
// [RULE11] Mode 1011 resets timer, pin uncontrolled
// [RULE12] Trigger immediate, timer cleared next timer edge
// [RULE13] Vanished match cancels the pending timer reset
// [RULE14] One action per entry into equality
package compare_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] VALUE_OFFSET  = 8'h04;
  localparam logic [7:0] FLAG_OFFSET   = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0c;

  // Control register fields
  localparam int         MODE_LSB     = 0;
  localparam int         MODE_W       = 4;
  localparam int         PIN_SEL_BIT  = 4;
  localparam int         CTRL_W       = 5;

  // Flag and status register fields
  localparam int         FLAG_BIT     = 0;
  localparam int         ST_EQUAL_BIT = 0;
  localparam int         ST_LEVEL_BIT = 1;
  localparam int         ST_PEND_BIT  = 2;

  // Compare mode codes
  localparam logic [3:0] MODE_OFF     = 4'h0;
  localparam logic [3:0] MODE_TOGGLE  = 4'h2;
  localparam logic [3:0] MODE_SET     = 4'h8;
  localparam logic [3:0] MODE_CLEAR   = 4'h9;
  localparam logic [3:0] MODE_SWINT   = 4'ha;
  localparam logic [3:0] MODE_SPECIAL = 4'hb;

  // Reset values
  localparam logic [3:0]  MODE_RST    = 4'h0;
  localparam logic [15:0] VALUE_RST   = 16'h0000;
  localparam logic        LEVEL_RST   = 1'b0;

endpackage

// ==== compare_match_detect.sv ====
`timescale 1ns/10ps
// Equality detector with entry-edge pulse
module compare_match_detect
  import compare_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset
  input  wire logic        enable_i,  // Compare mode selected
  input  wire logic [15:0] value_i,   // Compare value pair
  input  wire logic [15:0] count_i,   // Timer count pair
  output logic             equal_o,   // Live equality
  output logic             rise_o     // Pulse on entry into equality
);

  typedef struct packed {
    logic prev;  // Equality seen last cycle
  } detect_state_type;

  detect_state_type state_reg;
  detect_state_type state_next;

  // Equality is checked every cycle while enabled
  assign equal_o = enable_i && (value_i == count_i); // see [RULE1]
  // Only the first equal cycle acts
  assign rise_o  = equal_o && !state_reg.prev;       // see [RULE14]

  // Next state
  always_comb begin
    state_next      = state_reg;
    state_next.prev = equal_o;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // A pulse needs live equality behind it
  rise_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise_o |-> enable_i && value_i == count_i) // see [RULE1]
    else $error("match pulse without equality");

  // Staying equal gives no second pulse
  single_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    equal_o [*2] |-> !rise_o) // see [RULE14]
    else $error("repeated match pulse while equal");

endmodule

// ==== compare_out_latch.sv ====
`timescale 1ns/10ps
// Compare output latch driven by the mode field
module compare_out_latch
  import compare_pkg::*;
(
  input  wire logic       clk_i,       // System clock
  input  wire logic       rst_i,       // Synchronous reset
  input  wire logic       match_i,     // Match entry pulse
  input  wire logic [3:0] mode_i,      // Compare mode select
  input  wire logic       force_low_i, // Zero written to control
  output logic            level_o,     // Latch level
  output logic            drive_o      // Mode owns the pin
);

  typedef struct packed {
    logic level;  // Output latch
  } latch_state_type;

  latch_state_type state_reg;
  latch_state_type state_next;

  assign level_o = state_reg.level;
  // Only toggle, set and clear modes take the pin
  assign drive_o = (mode_i == MODE_TOGGLE) || (mode_i == MODE_SET) ||
                   (mode_i == MODE_CLEAR); // see [RULE10] [RULE11]

  // Next latch value
  always_comb begin
    state_next = state_reg;
    if (force_low_i) begin
      // Clearing the control register parks the latch low
      state_next.level = LEVEL_RST; // see [RULE7]
    end else if (match_i) begin
      case (mode_i)
        MODE_TOGGLE: state_next.level = !state_reg.level; // see [RULE2]
        MODE_SET:    state_next.level = 1'b1;             // see [RULE2]
        MODE_CLEAR:  state_next.level = 1'b0;             // see [RULE2]
        default:     state_next.level = state_reg.level;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.level <= LEVEL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Zero write lands low on the next edge
  force_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    force_low_i |=> !level_o) // see [RULE7]
    else $error("latch not forced low");

  // Toggle flips the level
  toggle_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_i && !force_low_i && mode_i == MODE_TOGGLE
    |=> level_o != $past(level_o)) // see [RULE2]
    else $error("toggle mode did not flip latch");

  // Set mode drives high
  set_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    match_i && !force_low_i && mode_i == MODE_SET |=> level_o) // see [RULE2]
    else $error("set mode did not raise latch");

endmodule

// ==== timer_partner.sv ====
`timescale 1ns/10ps
// Timer pair and conversion start model on the far side of the unit
module timer_partner #(
  parameter int TICK_DIV = 8  // System cycles per timer clock
)
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        rst_i,      // Synchronous reset
  input  wire logic        run_i,      // Timer counting
  input  wire logic        load_i,     // Load count pair
  input  wire logic [15:0] load_val_i, // Value to load
  input  wire logic        clear_i,    // Clear request from the unit
  input  wire logic        adc_go_i,   // Conversion start
  output logic             tick_o,     // Timer clock edge
  output logic [15:0]      count_o,    // Count pair
  output logic             ovf_flag_o, // Overflow flag
  output logic             adc_busy_o  // Conversion running
);
  logic [7:0] div_reg;   // Prescale counter
  logic [7:0] conv_reg;  // Conversion time left
  // Timer clock only runs while counting
  assign tick_o     = run_i && (div_reg == 8'h00);
  assign adc_busy_o = (conv_reg != 8'h00);
  // Count, clear and conversion state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg    <= 8'h00;
      conv_reg   <= 8'h00;
      count_o    <= 16'h0000;
      ovf_flag_o <= 1'b0;
    end else begin
      if (!run_i || div_reg == 8'(TICK_DIV - 1)) begin
        div_reg <= 8'h00;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
      if (load_i) begin
        count_o <= load_val_i;
      end else if (clear_i) begin
        count_o <= 16'h0000;  // Both bytes, flag untouched
      end else if (tick_o) begin
        count_o <= count_o + 16'h0001;
        if (count_o == 16'hffff) begin
          ovf_flag_o <= 1'b1;  // Only a real wrap sets it
        end
      end
      if (adc_go_i) begin
        conv_reg <= 8'h14;  // Conversion starts
      end else if (conv_reg != 8'h00) begin
        conv_reg <= conv_reg - 8'h01;
      end
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
// Self-checking bench for one second compare unit
module tb_top;
  import compare_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;   // Clock, bus
  logic [7:0]  adr_i;                                   // Bus address
  logic [3:0]  sel_i;                                   // Byte lanes
  logic [31:0] dat_i, dat_o, rdat;                      // Bus data
  logic        tick, clr, trigger_o, adc_go_o, flag_o;   // Events
  logic        pc_o, pc_oe_n, pb_o, pb_oe_n;            // Pins
  logic        run, load, ovf, adc_busy;                // Timer control
  logic [15:0] count, load_val, trig_count;             // Timer values
  int          bad_count, checks, trig_n, clr_n, adc_n; // Counters

  timer_compare_match_unit #(.SECOND_UNIT(1'b1)) u_timer_compare_match_unit (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .timer_one_count_i(count),
    .timer_tick_i(tick), .timer_clear_o(clr), .trigger_o(trigger_o),
    .adc_go_o(adc_go_o), .compare_match_flag_o(flag_o),
    .port_c_pin_one_o(pc_o), .port_c_pin_one_oe_n_o(pc_oe_n),
    .port_b_pin_three_o(pb_o), .port_b_pin_three_oe_n_o(pb_oe_n));

  timer_partner #(.TICK_DIV(8)) u_timer_partner (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .load_i(load),
    .load_val_i(load_val), .clear_i(clr), .adc_go_i(adc_go_o),
    .tick_o(tick), .count_o(count), .ovf_flag_o(ovf),
    .adc_busy_o(adc_busy));

  // Clock at 10 MHz
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Count event pulses and note the count at each trigger
  always @(posedge clk_i) begin
    if (trigger_o === 1'b1) begin
      trig_n++;
      trig_count = count;
    end
    if (clr === 1'b1) clr_n++;
    if (adc_go_o === 1'b1) adc_n++;
  end

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Classic Wishbone single cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) chk(32'h0, 32'h1);
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask

  // Stop the timer and load it
  task automatic tload(input logic [15:0] v);
    @(posedge clk_i);
    run <= 1'b0; load <= 1'b1; load_val <= v;
    @(posedge clk_i);
    load <= 1'b0;
  endtask

  // Reset values and an unmapped read
  task automatic t_reset();
    wb(1'b0, CTRL_OFFSET, 32'h0);   chk(rdat, 32'h0);
    wb(1'b0, VALUE_OFFSET, 32'h0);  chk(rdat, 32'h0);
    wb(1'b0, STATUS_OFFSET, 32'h0); chk(rdat, 32'h0);
    wb(1'b0, 8'h10, 32'h0);         chk(rdat, 32'h0);
    chk({flag_o, pc_oe_n, pb_oe_n}, 3'b011);
  endtask

  // One match in one mode, pin select and expected latch
  task automatic t_match(input logic [3:0] m, input logic ps,
                         input logic lvl, input logic drv);
    int n, t0, c0, a0;
    logic sp;
    sp = (m == MODE_SPECIAL);
    tload(16'h003d);
    wb(1'b1, CTRL_OFFSET, {27'h0, ps, m});
    wb(1'b1, FLAG_OFFSET, 32'h1);
    wb(1'b1, VALUE_OFFSET, 32'h0040);
    t0 = trig_n; c0 = clr_n; a0 = adc_n; n = 0;
    run <= 1'b1;
    while (flag_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    repeat (14) @(posedge clk_i);
    chk(flag_o, 1'b1);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rdat[ST_LEVEL_BIT], lvl);
    chk({pc_oe_n, pb_oe_n}, {!(drv && !ps), !(drv && ps)});
    // Pin level counts only in modes that drive the pin
    if (drv) chk(ps ? pb_o : pc_o, lvl);
    chk(trig_n - t0, sp);
    chk(adc_n - a0, sp);
    chk(clr_n - c0, sp);
    wb(1'b1, FLAG_OFFSET, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(flag_o, 1'b0);
    if (sp) begin
      chk(trig_count, 16'h0040);
      chk(count < 16'h0010, 1'b1);
      chk(ovf, 1'b0);
      n = 0;
      while (trig_n - t0 < 2 && n < 1000) begin
        @(posedge clk_i);
        n++;
      end
      chk(trig_n - t0, 2);
      // Let the conversion start land in the partner first
      @(posedge clk_i);
      chk(adc_busy, 1'b1);
    end
  endtask

  // Zero control write drops the latch
  task automatic t_zero();
    wb(1'b1, CTRL_OFFSET, 32'h0);
    repeat (2) @(posedge clk_i);
    wb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rdat[ST_LEVEL_BIT], 1'b0);
    chk({pc_oe_n, pb_oe_n}, 2'b11);
  endtask

  // Match withdrawn before the timer edge: no clear
  task automatic t_cancel();
    int c0;
    tload(16'h0100);
    wb(1'b1, CTRL_OFFSET, {28'h0, MODE_SPECIAL});
    c0 = clr_n;
    wb(1'b1, VALUE_OFFSET, 32'h0100);
    wb(1'b1, VALUE_OFFSET, 32'h0200);
    run <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk(clr_n - c0, 0);
    chk(count > 16'h0100, 1'b1);
  endtask

  // Verdict
  task automatic results();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #3000000;
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    bad_count = 0; checks = 0; trig_n = 0; clr_n = 0; adc_n = 0;
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0;
    adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0;
    run = 1'b0; load = 1'b0; load_val = 16'h0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_match(MODE_TOGGLE, 1'b0, 1'b1, 1'b1);
    t_match(MODE_CLEAR, 1'b1, 1'b0, 1'b1);
    t_match(MODE_SET, 1'b1, 1'b1, 1'b1);
    t_match(MODE_SWINT, 1'b0, 1'b1, 1'b0);
    t_match(MODE_SPECIAL, 1'b0, 1'b1, 1'b0);
    t_zero();
    t_cancel();
    results();
  end
endmodule
